// >>> src/msbi_core.sv
`timescale 1ns/1ps
`include "msbi_regs.svh"
module msbi_core
   import msbi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // program fetch / data transfer request from the core
   input  wire logic        req_valid,
   output logic             req_ready,
   input  msbi_req_t        req,
   input  wire logic        req_stack,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   output logic [15:0]      pc,
   input  wire logic        pc_load,
   input  wire logic [15:0] pc_load_val,
   input  wire logic [2:0]  vector_sel,
   output logic [15:0]      vector_addr,
   // internal program store
   output logic [11:0]      rom_addr,
   input  wire logic [7:0]  rom_data,
   // configuration
   input  wire logic        bus_float,
   input  wire logic        mux_port_mem,
   input  wire logic [1:0]  upper_nib_addr,
   input  wire logic        dm_enable,
   input  wire logic        stack_external,
   input  wire logic [7:0]  upper_gpio_out,
   input  wire logic [7:0]  upper_gpio_oe,
   // register file access
   input  wire logic        reg_we,
   input  wire logic [7:0]  reg_operand,
   input  wire logic        reg_short,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_pointer,
   output msbi_rdec_t       reg_dec,
   output logic [7:0]       stack_pointer_upper,
   output logic [7:0]       stack_pointer_lower,
   output logic [15:0]      stack_addr,
   output logic             stack_addr_ok,
   // pins
   output logic             addr_strobe_n,
   output logic             addr_strobe_oe,
   output logic             xfer_strobe_n,
   output logic             xfer_strobe_oe,
   output logic             rd_wr_n,
   output logic             rd_wr_oe,
   output logic             data_space_select_n,
   output logic [7:0]       mux_addr_data_port_o,
   output logic             mux_addr_data_port_oe,
   input  wire logic [7:0]  mux_addr_data_port_i,
   output logic [7:0]       upper_addr_port_o,
   output logic [7:0]       upper_addr_port_oe
);
   // sequencer state and the latched request
   msbi_state_t      state_q;
   msbi_state_t      state_d;
   msbi_req_t        cur_q;
   msbi_req_t        cur_d;
   msbi_req_t        cur_new;
   logic             started_q;
   logic             end_q;
   // program counter and stack pointer pair
   logic [15:0]      pc_q;
   logic [15:0]      pc_d;
   logic [7:0]       spu_q;
   logic [7:0]       spu_d;
   logic [7:0]       spl_q;
   logic [7:0]       spl_d;
   // answer path
   logic [7:0]       rdata_q;
   logic [7:0]       rdata_d;
   logic             rsp_q;
   logic             rsp_d;
   // two-stage synchroniser on the multiplexed port pins
   logic [7:0]       mux_s1_q;
   logic [7:0]       mux_s2_q;

   // request qualification and phase decode
   wire logic        is_internal;
   wire logic        take;
   wire logic        take_int;
   wire logic        take_ext;
   wire logic        ext_active;
   wire logic        addr_ph;
   wire logic        data_ph;
   wire logic        end_ph;
   wire logic        rd_data_ph;
   // register side
   wire logic        sp_we_u;
   wire logic        sp_we_l;
   wire logic        sp_in_gp;
   wire logic        vec_ok;
   wire logic [15:0] tgt_addr;
   wire logic [15:0] ext_stack_addr;
   wire logic [15:0] int_stack_addr;
   wire logic [7:0]  ext_rdata;

   // register file address decode, shared by all operand forms
   msbi_reg_decode u_dec (
      .reg_operand (reg_operand),
      .reg_short   (reg_short),
      .reg_pointer (reg_pointer),
      .dec         (reg_dec)
   );

   // stack transfers always target data space at the stack pointer address
   assign tgt_addr    = req_stack ? stack_addr : req.addr;
   assign is_internal = !req_stack && !req.data_space && (req.addr < `MSBI_INT_TOP);
   // refused while a machine cycle runs and while its read byte is still in the synchroniser
   assign req_ready   = (state_q == MSBI_IDLE) && started_q && !end_q;
   assign take        = req_valid && req_ready;
   assign take_int    = take && is_internal;
   assign take_ext    = take && !is_internal;

   // phases of the external machine cycle from the state register; the read data phase also uses cur_q.write
   assign ext_active  = (state_q != MSBI_IDLE);
   assign addr_ph     = (state_q == MSBI_ADDR);
   assign data_ph     = (state_q == MSBI_DATA);
   assign end_ph      = (state_q == MSBI_END);
   assign rd_data_ph  = data_ph && !cur_q.write;

   // machine cycle sequencer: idle -> addr -> data -> end; addr, data and end take one clock each
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         MSBI_IDLE: begin
            if (take_ext) begin
               state_d = MSBI_ADDR;
            end
         end
         MSBI_ADDR: state_d = MSBI_DATA;
         MSBI_DATA: state_d = MSBI_END;
         MSBI_END:  state_d = MSBI_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= MSBI_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // first cycle after reset release is spent loading the start address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   // the pin byte of a read reaches the second stage only one edge after
   // the end state, so the answer waits for this flag; costs one cycle per
   // external transfer but keeps the pins behind two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         end_q <= 1'b0;
      end else begin
         end_q <= end_ph;
      end
   end

   // latch the request so pins stay stable across the machine cycle
   assign cur_new = '{req.write, req.data_space || req_stack, tgt_addr, req.wdata};
   assign cur_d   = take_ext ? cur_new : cur_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
      end else begin
         cur_q <= cur_d;
      end
   end

   // program counter: 16 bits over the 64K space, changed only by pc_load
   assign pc_d = pc_load ? pc_load_val : pc_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= `MSBI_RESET_PC;
      end else begin
         pc_q <= pc_d;
      end
   end
   assign pc = pc_q;

   // vectors are byte pairs at the bottom of program space
   assign vec_ok      = (vector_sel < `MSBI_VEC_COUNT);
   assign vector_addr = vec_ok ? {12'h000, vector_sel, 1'b0} : `MSBI_RESET_PC;

   // the on-chip store sees the low 12 address bits straight from the request
   assign rom_addr = req.addr[11:0];

   // pad pins cross from outside: two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_s1_q <= 8'h00;
         mux_s2_q <= 8'h00;
      end else begin
         mux_s1_q <= mux_addr_data_port_i;
         mux_s2_q <= mux_s1_q;
      end
   end

   // answer: internal at once, external after the byte left the synchroniser;
   // the two never meet since requests are refused while end_q is high
   assign ext_rdata = cur_q.write ? cur_q.wdata : mux_s2_q;
   assign rsp_d     = take_int || end_q;
   assign rdata_d   = take_int ? rom_data : (end_q ? ext_rdata : rdata_q);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         rsp_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rsp_q   <= rsp_d;
      end
   end
   assign rsp_valid = rsp_q;
   assign rsp_data  = rdata_q;

   // stack pointer registers, written through the register file
   assign sp_we_u = reg_we && (reg_dec.addr == `MSBI_SP_UPPER);
   assign sp_we_l = reg_we && (reg_dec.addr == `MSBI_SP_LOWER);
   assign spu_d   = sp_we_u ? reg_wdata : spu_q;
   assign spl_d   = sp_we_l ? reg_wdata : spl_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spu_q <= `MSBI_SP_RESET;
         spl_q <= `MSBI_SP_RESET;
      end else begin
         spu_q <= spu_d;
         spl_q <= spl_d;
      end
   end
   assign stack_pointer_upper = spu_q;
   assign stack_pointer_lower = spl_q;

   // external stack spans both bytes; internal uses only the low byte
   assign ext_stack_addr = {spu_q, spl_q};
   assign int_stack_addr = {8'h00, spl_q};
   assign stack_addr     = stack_external ? ext_stack_addr : int_stack_addr;
   assign sp_in_gp       = (spl_q > `MSBI_PORT_TOP) && (spl_q <= `MSBI_GP_TOP);
   assign stack_addr_ok  = stack_external ? (ext_stack_addr >= `MSBI_STACK_MIN)
                                          : sp_in_gp;

   // strobes: address strobe low only in the addr state, once per cycle
   assign addr_strobe_n  = !addr_ph;
   assign xfer_strobe_n  = !data_ph;
   assign rd_wr_n        = !(ext_active && cur_q.write);
   // floating hands the strobes to another bus master
   assign addr_strobe_oe = !bus_float;
   assign xfer_strobe_oe = !bus_float;
   assign rd_wr_oe       = !bus_float;
   // shared program/data space when select disabled; pin is high idle
   assign data_space_select_n = !(dm_enable && ext_active && cur_q.data_space);

   // low port: address in addr and end phases (set up before strobe rises), data in the data phase;
   // released during a read data phase so the memory can drive it
   assign mux_addr_data_port_o  = data_ph ? cur_q.wdata : cur_q.addr[7:0];
   assign mux_addr_data_port_oe = mux_port_mem && !bus_float && ext_active
                                  && !rd_data_ph;

   // upper port: each nibble address or general I/O; an address nibble
   // floats with the bus, an I/O nibble keeps its own enables
   genvar n;
   generate
      for (n = 0; n < 2; n++) begin : g_nib
         assign upper_addr_port_o[n*4 +: 4]  = upper_nib_addr[n] ? cur_q.addr[8 + n*4 +: 4]
                                               : upper_gpio_out[n*4 +: 4];
         assign upper_addr_port_oe[n*4 +: 4] = upper_nib_addr[n] ? {4{!bus_float}}
                                               : upper_gpio_oe[n*4 +: 4];
      end
   endgenerate
endmodule

// >>> src/msbi_pkg.sv
package msbi_pkg;
   typedef enum logic [1:0] {
      MSBI_IDLE  = 2'b00,
      MSBI_ADDR  = 2'b01,
      MSBI_DATA  = 2'b11,
      MSBI_END   = 2'b10
   } msbi_state_t;
   // one external transfer request
   typedef struct packed {
      logic        write;
      logic        data_space;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } msbi_req_t;
   // register file decode result
   typedef struct packed {
      logic       is_port;
      logic       is_gp;
      logic       is_ctrl;
      logic       is_invalid;
      logic [7:0] addr;
   } msbi_rdec_t;
endpackage

// >>> src/msbi_reg_decode.sv
`timescale 1ns/1ps
`include "msbi_regs.svh"
module msbi_reg_decode
   import msbi_pkg::*;
(
   input  wire logic [7:0] reg_operand,
   input  wire logic       reg_short,
   input  wire logic [7:0] reg_pointer,
   output msbi_rdec_t      dec
);
   wire logic [7:0] eff_addr;
   wire logic       grp_ok;
   // short operands: pointer upper nibble picks a 16-register group
   assign eff_addr = reg_short ? {reg_pointer[7:4], reg_operand[3:0]} : reg_operand;
   // groups 0..7 and the control group 15 make the nine working groups
   assign grp_ok = (reg_pointer[7:4] < `MSBI_RP_MAX_GRP)
                || (reg_pointer[7:4] == `MSBI_RP_CTRL_GRP);
   assign dec.addr       = eff_addr;
   assign dec.is_port    = (eff_addr <= `MSBI_PORT_TOP);
   assign dec.is_gp      = (eff_addr > `MSBI_PORT_TOP) && (eff_addr <= `MSBI_GP_TOP);
   assign dec.is_ctrl    = (eff_addr >= `MSBI_CTRL_BASE);
   assign dec.is_invalid = !(dec.is_port || dec.is_gp || dec.is_ctrl) || (reg_short && !grp_ok);
endmodule

// >>> src/msbi_regs.svh
`ifndef MSBI_REGS_SVH
`define MSBI_REGS_SVH
// program space split
`define MSBI_INT_TOP      16'h1000
`define MSBI_RESET_PC     16'h000c
`define MSBI_VEC_BYTES    16'h000c
`define MSBI_VEC_COUNT    3'h6
// register file map
`define MSBI_PORT_TOP     8'h03
`define MSBI_GP_TOP       8'h7f
`define MSBI_CTRL_BASE    8'hf0
`define MSBI_SP_UPPER     8'hfe
`define MSBI_SP_LOWER     8'hff
`define MSBI_RP_MAX_GRP   4'h8
`define MSBI_RP_CTRL_GRP  4'hf
`define MSBI_STACK_MIN    16'h1000
`define MSBI_SP_RESET     8'h00
`endif

// >>> test/msbi_core_sva.sv
`timescale 1ns/1ps
module msbi_core_sva
   import msbi_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input msbi_req_t        req,
   input wire logic        req_stack,
   input wire logic        rsp_valid,
   input wire logic [15:0] pc,
   input wire logic        bus_float,
   input wire logic        addr_strobe_n,
   input wire logic        addr_strobe_oe,
   input wire logic        xfer_strobe_n,
   input wire logic        xfer_strobe_oe,
   input wire logic        rd_wr_n,
   input wire logic [7:0]  mux_addr_data_port_o,
   input wire logic        mux_addr_data_port_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a taken non-stack request that has to leave the chip
   wire ext = req_valid && req_ready && !req_stack && (req.data_space || req.addr >= 16'h1000);
   a_ext_answer: assert property (ext |-> ##5 rsp_valid)
      else $error("external answer late");
   a_reset_start: assert property ($rose(rst_n) |-> pc == 16'h000c)
      else $error("fetch start wrong");
   a_strobe_pulse: assert property ($fell(addr_strobe_n) |=> addr_strobe_n)
      else $error("address strobe too long");
   a_addr_phase: assert property (ext |=> !addr_strobe_n && mux_addr_data_port_oe
      && mux_addr_data_port_o == $past(req.addr[7:0])) else $error("address phase wrong");
   a_xfer_once: assert property (ext |=> xfer_strobe_n ##1 !xfer_strobe_n ##1 xfer_strobe_n)
      else $error("transfer strobe wrong");
   a_write_level: assert property (ext && req.write |=> !rd_wr_n [*3] ##1 rd_wr_n)
      else $error("write level wrong");
   a_read_level: assert property (ext && !req.write |=> rd_wr_n [*4])
      else $error("read level wrong");
   a_float_pins: assert property (bus_float |-> !addr_strobe_oe && !xfer_strobe_oe)
      else $error("strobes not floated");
   a_read_release: assert property (ext && !req.write |-> ##2 !mux_addr_data_port_oe)
      else $error("port not released");
   c_ext_write: cover property (ext && req.write);
   c_ext_read: cover property (ext && !req.write);
   c_float: cover property (bus_float);
endmodule

// >>> test/msbi_ext_mem.sv
`timescale 1ns/1ps
module msbi_ext_mem (
   input  wire logic       clk,
   input  wire logic       addr_strobe_n,
   input  wire logic       xfer_strobe_n,
   input  wire logic       rd_wr_n,
   input  wire logic [7:0] port_o,
   input  wire logic       port_oe,
   input  wire logic [7:0] upper_o,
   output logic      [7:0] port_i
);
   logic [7:0]  mem [0:255];
   logic [15:0] addr_q;
   logic [7:0]  last_q = 8'h5a;
   logic        hold_q = 1'b0;
   // read data held one cycle past the strobe, then the wire shows noise
   assign port_i = port_oe ? port_o
                 : ((!xfer_strobe_n && rd_wr_n) || hold_q) ? mem[addr_q[7:0]] : ~last_q;
   // address latched while the strobe is low
   always_ff @(posedge clk) begin
      if (!addr_strobe_n) addr_q <= {upper_o, port_o};
      // write data taken during the transfer strobe; low byte only, so images alias
      if (!xfer_strobe_n && !rd_wr_n && port_oe) mem[addr_q[7:0]] <= port_o;
      hold_q <= !xfer_strobe_n && rd_wr_n;
      last_q <= port_i;
   end
endmodule

// >>> test/tb_msbi_core.sv
`timescale 1ns/1ps
module tb_msbi_core;
   import msbi_pkg::*;
   logic        clk = 0, rst_n = 0, req_valid = 0, req_stack = 0, pc_load = 0, reg_we = 0;
   logic        dm_seen;
   logic        reg_short = 0, bus_float = 0, mux_port_mem = 1, dm_enable = 1;
   logic        stack_external = 1, req_ready, rsp_valid, stack_addr_ok, rd_wr_n, rd_wr_oe;
   logic        addr_strobe_n, addr_strobe_oe, xfer_strobe_n, xfer_strobe_oe;
   logic        data_space_select_n, mux_addr_data_port_oe;
   logic [1:0]  upper_nib_addr = 2'h3;
   logic [2:0]  vector_sel = 3'h0;
   logic [7:0]  rom_data = 8'h3c, upper_gpio_out = 8'ha0, upper_gpio_oe = 8'hf0;
   logic [7:0]  reg_operand = 8'h00, reg_wdata = 8'h00, reg_pointer = 8'h00, got, up_seen;
   logic [7:0]  rsp_data, stack_pointer_upper, stack_pointer_lower, mux_addr_data_port_o;
   logic [7:0]  mux_addr_data_port_i, upper_addr_port_o, upper_addr_port_oe;
   logic [15:0] pc, vector_addr, stack_addr, pc_load_val = 16'h0000;
   logic [11:0] rom_addr;
   msbi_req_t   req = '0;
   msbi_rdec_t  reg_dec;
   int          error_cnt = 0, check_count = 0;
   msbi_core i_dut (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .req_valid             (req_valid),
      .req_ready             (req_ready),
      .req                   (req),
      .req_stack             (req_stack),
      .rsp_valid             (rsp_valid),
      .rsp_data              (rsp_data),
      .pc                    (pc),
      .pc_load               (pc_load),
      .pc_load_val           (pc_load_val),
      .vector_sel            (vector_sel),
      .vector_addr           (vector_addr),
      .rom_addr              (rom_addr),
      .rom_data              (rom_data),
      .bus_float             (bus_float),
      .mux_port_mem          (mux_port_mem),
      .upper_nib_addr        (upper_nib_addr),
      .dm_enable             (dm_enable),
      .stack_external        (stack_external),
      .upper_gpio_out        (upper_gpio_out),
      .upper_gpio_oe         (upper_gpio_oe),
      .reg_we                (reg_we),
      .reg_operand           (reg_operand),
      .reg_short             (reg_short),
      .reg_wdata             (reg_wdata),
      .reg_pointer           (reg_pointer),
      .reg_dec               (reg_dec),
      .stack_pointer_upper   (stack_pointer_upper),
      .stack_pointer_lower   (stack_pointer_lower),
      .stack_addr            (stack_addr),
      .stack_addr_ok         (stack_addr_ok),
      .addr_strobe_n         (addr_strobe_n),
      .addr_strobe_oe        (addr_strobe_oe),
      .xfer_strobe_n         (xfer_strobe_n),
      .xfer_strobe_oe        (xfer_strobe_oe),
      .rd_wr_n               (rd_wr_n),
      .rd_wr_oe              (rd_wr_oe),
      .data_space_select_n   (data_space_select_n),
      .mux_addr_data_port_o  (mux_addr_data_port_o),
      .mux_addr_data_port_oe (mux_addr_data_port_oe),
      .mux_addr_data_port_i  (mux_addr_data_port_i),
      .upper_addr_port_o     (upper_addr_port_o),
      .upper_addr_port_oe    (upper_addr_port_oe)
   );
   msbi_ext_mem i_mem (.clk(clk), .addr_strobe_n(addr_strobe_n), .xfer_strobe_n(xfer_strobe_n),
      .rd_wr_n(rd_wr_n), .port_o(mux_addr_data_port_o), .port_oe(mux_addr_data_port_oe),
      .upper_o(upper_addr_port_o), .port_i(mux_addr_data_port_i));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // request raised for one clock once ready, answer awaited for a bounded time
   task automatic xfer(input logic wr, ds, input logic [15:0] a, input logic [7:0] wd,
                       output int lat);
      lat = 0;
      while (!req_ready && lat < 20) begin
         @(negedge clk);
         lat++;
      end
      req = '{write: wr, data_space: ds, addr: a, wdata: wd};
      req_valid = 1;
      @(negedge clk);
      req_valid = 0;
      up_seen = upper_addr_port_o;
      dm_seen = data_space_select_n;
      lat = 1;
      while (!rsp_valid && lat < 20) begin
         @(negedge clk);
         lat++;
      end
      got = rsp_data;
   endtask
   task automatic t_space;
      int lat;
      pc_load_val = 16'hfffe;
      pc_load = 1;
      @(negedge clk);
      pc_load = 0;
      chk("pc load", pc, 16'hfffe);
      xfer(0, 0, 16'h0fff, 8'h00, lat);
      chk("int lat", lat, 1);
      chk("int data", got, 8'h3c);
      chk("rom addr", rom_addr, 12'hfff);
      xfer(0, 0, 16'h1000, 8'h00, lat);
      chk("ext lat", lat, 5);
      chk("dm prog", dm_seen, 1'b1);
   endtask
   task automatic t_ext;
      int lat;
      xfer(1, 1, 16'h1234, 8'ha5, lat);
      chk("wr lat", lat, 5);
      chk("wr echo", got, 8'ha5);
      chk("dm data", dm_seen, 1'b0);
      chk("upper", up_seen, 8'h12);
      xfer(0, 1, 16'h1234, 8'h00, lat);
      chk("rd data", got, 8'ha5);
      upper_nib_addr = 2'h1;
      xfer(1, 1, 16'h0534, 8'h5a, lat);
      chk("nibble", up_seen, 8'ha5);
      upper_nib_addr = 2'h3;
      bus_float = 1;
      @(negedge clk);
      chk("float", {addr_strobe_oe, xfer_strobe_oe, rd_wr_oe, mux_addr_data_port_oe,
         upper_addr_port_oe}, 12'h000);
      bus_float = 0;
   endtask
   task automatic t_regs;
      // short flag, pointer group, operand, expected is_port/is_gp/is_ctrl/is_invalid
      logic [16:0] tbl [7] = '{{1'b0, 4'h0, 8'h03, 4'h8}, {1'b0, 4'h0, 8'h04, 4'h4},
         {1'b0, 4'h0, 8'h7f, 4'h4}, {1'b0, 4'h0, 8'hf0, 4'h2}, {1'b0, 4'h0, 8'h80, 4'h1},
         {1'b1, 4'h7, 8'h05, 4'h4}, {1'b1, 4'hf, 8'h0e, 4'h2}};
      for (int i = 0; i < 7; i++) begin
         {reg_short, reg_pointer, reg_operand} = {tbl[i][16:12], 4'h0, tbl[i][11:4]};
         @(negedge clk);
         chk("decode", reg_dec, {tbl[i][3:0], tbl[i][16] ? {tbl[i][15:12], tbl[i][7:4]}
            : tbl[i][11:4]});
      end
      for (int s = 0; s < 8; s++) begin
         vector_sel = 3'(s);
         @(negedge clk);
         chk("vector", vector_addr, s < 6 ? 16'(2 * s) : 16'h000c);
      end
      reg_short = 0;
      {reg_we, reg_operand, reg_wdata} = {1'b1, 8'hfe, 8'h12};
      @(negedge clk);
      {reg_operand, reg_wdata} = {8'hff, 8'h34};
      @(negedge clk);
      reg_we = 0;
      chk("sp ext", {stack_addr_ok, stack_addr}, 17'h11234);
      stack_external = 0;
      @(negedge clk);
      chk("sp int", {stack_addr_ok, stack_addr}, 17'h10034);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      chk("rst pins", {pc, addr_strobe_n, xfer_strobe_n, rd_wr_n}, 19'h00067);
      chk("rst sp", stack_pointer_lower, 8'h00);
      rst_n = 1;
      @(negedge clk);
      t_space;
      t_ext;
      t_regs;
      complete_run;
   end
   // a hang is cut short long after the expected run of about 45 cycles
   initial begin
      #40000;
      error_cnt++;
      complete_run;
   end
endmodule
bind msbi_core msbi_core_sva i_sva (
   .clk                   (clk),
   .rst_n                 (rst_n),
   .req_valid             (req_valid),
   .req_ready             (req_ready),
   .req                   (req),
   .req_stack             (req_stack),
   .rsp_valid             (rsp_valid),
   .pc                    (pc),
   .bus_float             (bus_float),
   .addr_strobe_n         (addr_strobe_n),
   .addr_strobe_oe        (addr_strobe_oe),
   .xfer_strobe_n         (xfer_strobe_n),
   .xfer_strobe_oe        (xfer_strobe_oe),
   .rd_wr_n               (rd_wr_n),
   .mux_addr_data_port_o  (mux_addr_data_port_o),
   .mux_addr_data_port_oe (mux_addr_data_port_oe)
);
